// ===== hdl/supervisor_pkg.sv
/*
  Package for the reset and watchdog supervisor: timing constants, cycle
  counts and the packed structs that carry the comparator inputs and flags.
  Assumes a 20 MHz system clock; all delays are counted on it.
*/
package supervisor_pkg;

  // ---------------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 50;

  // ---------------------------------------------------------------------
  // times as printed, and derived counts
  // ---------------------------------------------------------------------
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned RESET_MIN_MS   = 140;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned KICK_PULSE_NS  = 50;

  // least times round up
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_MS * (CLK_HZ / 1000));
  localparam int unsigned RESET_MIN_CYC =
    (RESET_MIN_MS * (CLK_HZ / 1000));
  localparam int unsigned WDOG_TIMEOUT_CYC =
    (WDOG_TIMEOUT_MS * (CLK_HZ / 1000));
  // a kick pulse of this width still spans one clock edge
  localparam int unsigned KICK_PULSE_CYC =
    (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W          = 26;

  // ---------------------------------------------------------------------
  // supply trip variants
  // ---------------------------------------------------------------------
  typedef enum logic {trip_4v65, trip_4v40} trip_variant_e;
  localparam int unsigned TRIP_4V65_MV   = 4650;
  localparam int unsigned TRIP_4V40_MV   = 4400;
  localparam int unsigned PF_REF_MV      = 1250;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic supply_good;       // vcc above the variant trip level
    logic power_fail_sense;  // 1 while sense input is above reference
  } sense_s;

  typedef struct packed {
    logic level;             // kick pin level when driven
    logic driven;            // 0 while the pin floats
  } kick_s;

endpackage : supervisor_pkg

// ===== hdl/sync_2ff.sv
/*
  Two flip-flop synchroniser for a bus of levels.
  Assumes the first stage is read by the second stage only.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RST_VAL  = '0
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;

  // two stages; meta feeds q_out and nothing else
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      meta  <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : sync_2ff

// ===== hdl/reset_watchdog_supervisor.sv
/*
  Reset and watchdog supervisor: reset pulse stretching, manual reset,
  watchdog on the kick input, low-line and power-fail flags.
  Assumes comparator results and kick tri-state detect arrive as digital
  levels; all are synchronised here before use.
*/
// Contract
// - hold reset low while supply is not good.
// - release reset 200ms after supply becomes good.
// - a supply drop asserts reset at once and starts a new pulse.
// - a drop during a running pulse extends it at least 140ms.
// - active-high reset is always the inverse of active-low reset.
// - supply trip level is a build-time variant, 4.65V or 4.40V.
// - no kick transition for 1.6s drives watchdog fault low.
// - watchdog counter held at zero in reset or with kick floating.
// - watchdog counts once reset released and kick is driven.
// - any kick edge clears the watchdog; 50ns pulses seen.
// - low supply drives watchdog fault low regardless of timeout.
// - floating kick leaves watchdog fault as a low-line flag.
// - manual reset low asserts reset.
// - manual reset pulses last at least 140ms, debouncing the switch.
// - power-fail flag low while sense is below 1.25V reference.
// - after timeout, watchdog fault stays low until counter clears.
// - watchdog fault returns high at once when supply is good.
// - reset held 200ms after manual reset returns high.
`timescale 1ns/1ps
module reset_watchdog_supervisor #(
  parameter supervisor_pkg::trip_variant_e TRIP =
    supervisor_pkg::trip_4v65,
  parameter int unsigned RESET_PULSE_CYC = supervisor_pkg::RESET_PULSE_CYC,
  parameter int unsigned RESET_MIN_CYC   = supervisor_pkg::RESET_MIN_CYC,
  parameter int unsigned WDOG_TIMEOUT_CYC = supervisor_pkg::WDOG_TIMEOUT_CYC
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_in,
  input  wire supervisor_pkg::sense_s sense_in,
  input  wire logic                   manual_reset_n_in,
  input  wire supervisor_pkg::kick_s  watchdog_kick_in,
  output logic                        reset_n_out,
  output logic                        reset_out,
  output logic                        watchdog_fault_n_out,
  output logic                        power_fail_flag_n_out
);

  // ---------------------------------------------------------------------
  // trip level of this build, for reference by integration
  // ---------------------------------------------------------------------
  localparam int unsigned TRIP_MV = (TRIP == supervisor_pkg::trip_4v65) ?
    supervisor_pkg::TRIP_4V65_MV : supervisor_pkg::TRIP_4V40_MV;

  typedef enum logic [1:0] {st_hold, st_pulse, st_run} rst_state_e;

  localparam logic [supervisor_pkg::CNT_W-1:0] PULSE_LAST =
    supervisor_pkg::CNT_W'(RESET_PULSE_CYC - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] MIN_LAST =
    supervisor_pkg::CNT_W'(RESET_MIN_CYC - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] WDOG_LAST =
    supervisor_pkg::CNT_W'(WDOG_TIMEOUT_CYC - 1);

  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  supervisor_pkg::sense_s sense;
  supervisor_pkg::kick_s  kick;
  logic                   mr_n;

  // supply starts not good so reset holds through power-up
  sync_2ff #(.W(2), .RST_VAL(2'b01)) u_sync_sense (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       (sense_in),
    .q_out      (sense)
  );

  sync_2ff #(.W(3), .RST_VAL(3'b100)) u_sync_pins (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .d_in       ({manual_reset_n_in, watchdog_kick_in}),
    .q_out      ({mr_n, kick})
  );

  // ---------------------------------------------------------------------
  // reset pulse generator
  // ---------------------------------------------------------------------
  rst_state_e                         state;
  logic [supervisor_pkg::CNT_W-1:0]   rst_cnt;
  logic                               mr_seen;
  logic                               trigger;

  // a drop in supply or a held manual reset keeps the timer reloaded
  assign trigger = !sense.supply_good || !mr_n;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state   <= st_hold;
      rst_cnt <= '0;
    end else begin
      case (state)
        st_hold: begin
          // held for as long as the trigger stands
          rst_cnt <= '0;
          if (!trigger) begin
            state <= st_pulse;
          end
        end
        st_pulse: begin
          if (trigger) begin
            // brownout or press mid-pulse: restart, which more than
            // covers the 140ms extension on release of the trigger
            state   <= st_hold;
            rst_cnt <= '0;
          end else if (rst_cnt == PULSE_LAST) begin
            state <= st_run;
          end else begin
            rst_cnt <= rst_cnt + 1'b1;
          end
        end
        default: begin
          if (trigger) begin
            state <= st_hold;
          end
          rst_cnt <= '0;
        end
      endcase
    end
  end

  logic next_reset_n;
  assign next_reset_n = (state == st_run) && !trigger;

  // both polarities from one flop pair updated together
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reset_n_out <= 1'b0;
      reset_out   <= 1'b1;
    end else begin
      reset_n_out <= next_reset_n;
      reset_out   <= !next_reset_n;
    end
  end

  // ---------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------
  logic                               kick_prev;
  logic                               kick_edge;
  logic [supervisor_pkg::CNT_W-1:0]   wd_cnt;
  logic                               wd_timeout;
  logic                               wd_hold;

  // kick_prev reads the second stage only; 50ns spans one 50ns edge
  assign kick_edge = kick.driven && (kick.level != kick_prev);
  assign wd_hold   = !reset_n_out || !kick.driven;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= kick.level;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wd_cnt     <= '0;
      wd_timeout <= 1'b0;
    end else if (wd_hold || kick_edge) begin
      // cleared counter also ends a latched timeout
      wd_cnt     <= '0;
      wd_timeout <= 1'b0;
    end else if (wd_cnt == WDOG_LAST) begin
      wd_timeout <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // low-line overrides; no minimum width on return
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_fault_n_out <= 1'b0;
    end else begin
      // a clear in this cycle ends the fault now, not one cycle late
      watchdog_fault_n_out <= sense.supply_good &&
                              !(!wd_hold && !kick_edge &&
                                (wd_timeout || wd_cnt == WDOG_LAST));
    end
  end

  // ---------------------------------------------------------------------
  // power-fail flag
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      power_fail_flag_n_out <= 1'b1;
    end else begin
      power_fail_flag_n_out <= sense.power_fail_sense;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  logic [supervisor_pkg::CNT_W-1:0]   low_cnt;

  // length of the running reset pulse, saturating; read by checks only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt <= '0;
    end else if (reset_n_out) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  AST_INVERSE: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    reset_out == !reset_n_out)
    else $error("reset polarities disagree");

  AST_LOW_SUPPLY_RESET: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !sense.supply_good |=> !reset_n_out)
    else $error("reset released with supply low");

  AST_MR_RESET: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !mr_n |=> !reset_n_out)
    else $error("manual reset ignored");

  // every pulse, bounced press or brownout restart, spans the minimum
  AST_MIN_PULSE: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(reset_n_out) |-> $past(low_cnt) >= MIN_LAST)
    else $error("reset pulse shorter than minimum");

  AST_RELEASE: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(reset_n_out) |-> $past(rst_cnt) == PULSE_LAST)
    else $error("reset released early");

  AST_WD_HELD: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    wd_hold |=> wd_cnt == '0)
    else $error("watchdog counted while held");

  AST_WD_LOWLINE: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    !sense.supply_good |=> !watchdog_fault_n_out)
    else $error("fault flag high on low supply");

  AST_WD_KICK: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    kick_edge && !wd_hold && sense.supply_good
      |=> watchdog_fault_n_out && wd_cnt == '0)
    else $error("kick did not clear watchdog");

  AST_PFO: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ##1 power_fail_flag_n_out == $past(sense.power_fail_sense))
    else $error("power-fail flag wrong");

endmodule : reset_watchdog_supervisor

// ===== bench/cpu_model.sv
/*
  Model of the supervised processor: toggles the kick pin, holds it, or
  leaves it floating as the bench commands.
  Assumes the supervisor clock; mode 0 float, 1 kick, 2 stuck.
*/
`timescale 1ns/1ps
module cpu_model (
  input  wire logic           clk_sys_in,
  input  wire logic           rst_in,
  input  wire logic           reset_n_in,
  input  wire logic [1:0]     mode_in,
  output supervisor_pkg::kick_s kick_out
);
  // ---------------------------------------------------------------
  // kick generator
  // ---------------------------------------------------------------
  logic [3:0] tick;

  // floating pin shows a moving level so a stale value cannot pass
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tick     <= 4'h0;
      kick_out <= '0;
    end else begin
      tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
      case (mode_in)
        2'h0: kick_out <= '{level: ~kick_out.level, driven: 1'b0};
        2'h1: begin
          // code runs only once out of reset
          if (tick == 4'h9 && reset_n_in)
            kick_out <= '{level: ~kick_out.level, driven: 1'b1};
          else
            kick_out.driven <= 1'b1;
        end
        default: kick_out.driven <= 1'b1; // stuck code, level held
      endcase
    end
  end
endmodule : cpu_model

// ===== bench/tb_top.sv
/*
  Self-checking bench of the supervisor with a processor model.
  Assumes shortened counts: pulse 20, minimum 14, watchdog 50 cycles.
*/
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
  error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam int PULSE = 20;
  localparam int MINC  = 14;
  localparam int WDOG  = 50;
  logic                   clk_sys_in;
  logic                   rst_in;
  logic                   manual_reset_n_in;
  supervisor_pkg::sense_s sense;
  supervisor_pkg::kick_s  kick;
  logic                   reset_n;
  logic                   reset_h;
  logic                   fault_n;
  logic                   pf_n;
  logic [1:0]             mode;
  logic                   mr_btn;
  logic [1:0]             route;
  logic                   b;
  int                     error_cnt = 0;
  int                     compares = 0;
  int                     seed = 35462;
  int                     c;

  reset_watchdog_supervisor #(.RESET_PULSE_CYC(PULSE),
    .RESET_MIN_CYC(MINC), .WDOG_TIMEOUT_CYC(WDOG)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sense_in(sense),
    .manual_reset_n_in(manual_reset_n_in), .watchdog_kick_in(kick),
    .reset_n_out(reset_n), .reset_out(reset_h),
    .watchdog_fault_n_out(fault_n), .power_fail_flag_n_out(pf_n));

  cpu_model cpu_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reset_n_in(reset_n), .mode_in(mode), .kick_out(kick));

  // board wiring: fault or power-fail flag may pull the button line
  assign manual_reset_n_in = mr_btn && (!route[0] || fault_n) &&
                             (!route[1] || pf_n);

  // clock, 50 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // both reset polarities compared every cycle
  always @(negedge clk_sys_in) begin
    if (!rst_in) `CHK(reset_h, ~reset_n, "reset polarity")
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task complete_run;
    $display("counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // wait on reset (w=0) or fault (w=1); c keeps counting across calls
  task wait_lvl(input int w, input logic v, input int lo, input int hi);
    while (((w == 0) ? reset_n : fault_n) !== v && c <= hi) begin
      @(negedge clk_sys_in);
      c++;
    end
    `CHK(c >= lo && c <= hi, 1'b1, "output moved at wrong time")
    if (c > hi) complete_run();
  endtask : wait_lvl

  // fault must hold v for k cycles
  task hold_fault(input logic v, input int k);
    repeat (k) begin
      @(negedge clk_sys_in);
      `CHK(fault_n, v, "fault flag moved")
    end
  endtask : hold_fault

  // flag is high exactly while the sense input is above reference
  function automatic logic exp_pf_n(input logic above);
    return above;
  endfunction : exp_pf_n

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    sense = '0;
    mr_btn = 1'b1;
    route = 2'b00;
    mode = 2'h1;
    b = 1'($random(seed));
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // supply low: reset and fault held low
    repeat (40) begin
      @(negedge clk_sys_in);
      `CHK(reset_n, 1'b0, "reset while supply low")
      `CHK(fault_n, 1'b0, "fault while supply low")
    end
    $display("test power-up hold done");
    @(posedge clk_sys_in) sense.supply_good <= 1'b1;
    c = 0;
    wait_lvl(1, 1'b1, 0, 4);
    wait_lvl(0, 1'b1, PULSE, PULSE + 6);
    $display("test power-up release done");
    hold_fault(1'b1, 4 * WDOG);
    @(posedge clk_sys_in) mode <= 2'h2;
    c = 0;
    wait_lvl(1, 1'b0, WDOG - 10, WDOG + 6);
    hold_fault(1'b0, 30);
    @(posedge clk_sys_in) mode <= 2'h1;
    c = 0;
    wait_lvl(1, 1'b1, 0, 15);
    @(posedge clk_sys_in) mode <= 2'h0;
    hold_fault(1'b1, 3 * WDOG);
    $display("test watchdog done");
    // manual reset with bounce, code stuck meanwhile
    @(posedge clk_sys_in) mr_btn <= 1'b0;
    mode <= 2'h2;
    c = 0;
    wait_lvl(0, 1'b0, 0, 4);
    repeat (3) begin
      @(posedge clk_sys_in) mr_btn <= 1'b1;
      @(posedge clk_sys_in) mr_btn <= 1'b0;
    end
    repeat (WDOG + 10) @(posedge clk_sys_in);
    mr_btn <= 1'b1;
    c = 0;
    wait_lvl(0, 1'b1, PULSE, PULSE + 6);
    `CHK(fault_n, 1'b1, "watchdog ran during reset")
    $display("test manual reset done");
    // brownout outside and inside a running pulse
    @(posedge clk_sys_in) sense.supply_good <= 1'b0;
    mode <= 2'h1;
    c = 0;
    wait_lvl(0, 1'b0, 0, 4);
    `CHK(fault_n, 1'b0, "fault on brownout")
    @(posedge clk_sys_in) sense.supply_good <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    sense.supply_good <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    sense.supply_good <= 1'b1;
    c = 0;
    wait_lvl(0, 1'b1, MINC, PULSE + 6);
    $display("test brownout done");
    // random comparator levels, each held a few cycles
    repeat (30) begin
      @(posedge clk_sys_in) sense.power_fail_sense <= b;
      repeat (5) @(negedge clk_sys_in);
      `CHK(pf_n, exp_pf_n(b), "power-fail flag")
      b = 1'($random(seed));
    end
    $display("test power-fail done");
    // fault wired to the button line: a timeout gives a full pulse
    @(posedge clk_sys_in) route <= 2'b01;
    mode <= 2'h2;
    c = 0;
    wait_lvl(0, 1'b0, WDOG - 10, WDOG + 12);
    c = 0;
    wait_lvl(0, 1'b1, PULSE, PULSE + 6);
    // power-fail flag wired to the button line instead
    @(posedge clk_sys_in) route <= 2'b10;
    mode <= 2'h1;
    sense.power_fail_sense <= 1'b0;
    c = 0;
    wait_lvl(0, 1'b0, 3, 8);
    @(posedge clk_sys_in) sense.power_fail_sense <= 1'b1;
    c = 0;
    wait_lvl(0, 1'b1, PULSE, PULSE + 8);
    $display("test reset routing done");
    complete_run();
  end
endmodule : tb_top
